// >>> common/asc_pkg.sv
// Package of constants and types for the serial converter control block.
package asc_pkg;
	localparam int RESULT_W = 12;
	localparam int WORD_W = 13;
	localparam logic [3:0] WORD_LAST = 4'hc;
	localparam int CLK_RATE_MHZ = 20;
	localparam int LIGHT_WAKE_NS = 350;
	localparam int LIGHT_WAKE_CYC = (LIGHT_WAKE_NS * CLK_RATE_MHZ) / 1000;
	localparam int DEEP_WAKE_MS = 4;
	localparam int DEEP_WAKE_CYC = DEEP_WAKE_MS * CLK_RATE_MHZ * 1000;
	localparam int START_TO_CLOCK_NS = 100;
	localparam int START_TO_CLOCK_CYC = (START_TO_CLOCK_NS * CLK_RATE_MHZ + 999) / 1000;
	localparam int CONVERSION_START_STROBE_CYC_DEF = 40;
	localparam int WAKE_W = 17;
	localparam int CNT_W = 8;
	localparam logic [2:0] PULSES_LIGHT = 3'h2;
	localparam logic [2:0] PULSES_DEEP = 3'h4;
	localparam logic [RESULT_W-1:0] BIPOLAR_FLIP = 12'h800;
	typedef enum logic [1:0] {
		ASC_ACTIVE,
		ASC_LIGHT,
		ASC_DEEP
	} asc_power_type;
endpackage : asc_pkg

// >>> logic/asc_sync.sv
// Two flip-flop synchroniser for a pin input.
`timescale 1ns/100ps
module asc_sync (
	// Clock and reset.
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	// Pin and result.
	input wire logic i_pin,
	output logic o_level
);
	logic meta_ff;

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			meta_ff <= 1'b0;
			o_level <= 1'b0;
		end else begin
			meta_ff <= i_pin;
			o_level <= meta_ff;
		end
	end
endmodule : asc_sync

// >>> logic/asc_ctrl.sv
// Serial converter control: conversion sequencing, serial output and power states.
// Operation
// - Comes out of reset active, ready to convert without wake-up.
// - Clock low plus two start pulses enters light power-down.
// - Clock low plus four start pulses enters deep power-down.
// - Light power-down switches everything off except the reference.
// - Deep power-down switches everything off including the reference.
// - Rising serial clock wakes the device from either power-down.
// - Light power-down wake completes within 350ns.
// - Deep power-down wake takes about 4ms, waiting on reference ramp.
// - Reference-settled flag rises only once the reference has settled.
// - Reference-settled flag is shifted out before result bits.
// - Three lines: clock and start in, serial data out.
// - Conversion starts on rising edge of start strobe.
// - Start edges during a running conversion are ignored.
// - Clock too soon after start delays output by one clock.
// - Serial output changes only on rising serial clock edges.
// - Unipolar results span all zeros to all ones.
// - Bipolar results are two's complement around zero.
// - Unipolar coding is straight binary.
// - Flag forced low while reference is pulled below nominal.
`timescale 1ns/100ps
module asc_ctrl #(
	parameter int DEEP_WAKE_CYCLES = asc_pkg::DEEP_WAKE_CYC
) (
	// Clock and reset.
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	// Serial pins from the host.
	input wire logic i_sclk,
	input wire logic i_conversion_start_strobe,
	// Converter core side.
	input wire logic [asc_pkg::RESULT_W-1:0] i_sar_code,
	input wire logic i_bipolar,
	input wire logic i_ref_low,
	// Serial data to the host.
	output logic o_sdata,
	// Power controls and status.
	output logic o_core_power_en,
	output logic o_ref_power_en,
	output logic o_reference_settled_flag,
	output logic o_converting,
	output logic o_sample_req
);
	import asc_pkg::*;

	function automatic logic [CNT_W-1:0] dec_sat(input logic [CNT_W-1:0] v);
		dec_sat = (v == '0) ? v : v - 8'h01;
	endfunction : dec_sat

	logic sclk_s;
	logic conversion_start_strobe_s;
	logic sclk_d_ff;
	logic conversion_start_strobe_d_ff;
	asc_power_type pwr_ff;
	asc_power_type nxt_pwr;
	logic [2:0] pulse_cnt_ff;
	logic [2:0] nxt_pulse_cnt;
	logic [CNT_W-1:0] wake_cnt_ff;
	logic [WAKE_W-1:0] ref_cnt_ff;
	logic ref_ok_ff;
	logic busy_ff;
	logic [CNT_W-1:0] conversion_start_strobe_cnt_ff;
	logic [CNT_W-1:0] early_cnt_ff;
	logic early_ff;
	logic [WORD_W-1:0] shift_ff;
	logic [3:0] bit_cnt_ff;
	logic shifting_ff;
	logic skip_ff;

	asc_sync u_sync_sclk (
		.i_ref_clk(i_ref_clk),
		.i_rst_b(i_rst_b),
		.i_pin(i_sclk),
		.o_level(sclk_s)
	);
	asc_sync u_sync_conversion_start_strobe (
		.i_ref_clk(i_ref_clk),
		.i_rst_b(i_rst_b),
		.i_pin(i_conversion_start_strobe),
		.o_level(conversion_start_strobe_s)
	);

	// Only two input pins are watched, matching the three-line link.
	wire sclk_rise = sclk_s & ~sclk_d_ff;
	wire conversion_start_strobe_rise = conversion_start_strobe_s & ~conversion_start_strobe_d_ff;
	wire powered_down = (pwr_ff != ASC_ACTIVE);
	wire waking = (wake_cnt_ff != '0);
	wire ready = (pwr_ff == ASC_ACTIVE) & ~waking & ref_ok_ff;
	// A strobe while the clock is low is counted, never a conversion when asleep.
	wire start_ok = conversion_start_strobe_rise & ~busy_ff & ready & sclk_s;
	wire count_pulse = conversion_start_strobe_rise & ~sclk_s & ~busy_ff;
	wire conversion_start_strobe_done = busy_ff & (conversion_start_strobe_cnt_ff == 8'h01);
	wire ref_good = ref_ok_ff & ~i_ref_low;
	// Unipolar is straight binary; bipolar output flips the top bit into two's complement.
	wire [RESULT_W-1:0] coded = i_bipolar ? (i_sar_code ^ BIPOLAR_FLIP) : i_sar_code;

	always_comb begin
		nxt_pwr = pwr_ff;
		nxt_pulse_cnt = pulse_cnt_ff;
		if (sclk_rise) begin
			nxt_pwr = ASC_ACTIVE;
			nxt_pulse_cnt = 3'h0;
		end else if (count_pulse) begin
			nxt_pulse_cnt = (pulse_cnt_ff == PULSES_DEEP) ? pulse_cnt_ff : pulse_cnt_ff + 3'h1;
			if (nxt_pulse_cnt == PULSES_LIGHT) begin
				nxt_pwr = ASC_LIGHT;
			end else if (nxt_pulse_cnt == PULSES_DEEP) begin
				nxt_pwr = ASC_DEEP;
			end
		end
	end

	// Edge detectors run one clock behind the synchronisers, so every pin edge is seen three clocks late.
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sclk_d_ff <= 1'b0;
		end else begin
			sclk_d_ff <= sclk_s;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			conversion_start_strobe_d_ff <= 1'b0;
		end else begin
			conversion_start_strobe_d_ff <= conversion_start_strobe_s;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pwr_ff <= ASC_ACTIVE;
		end else begin
			pwr_ff <= nxt_pwr;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pulse_cnt_ff <= 3'h0;
		end else begin
			pulse_cnt_ff <= nxt_pulse_cnt;
		end
	end

	// Wake timing: a short fixed hold-off after light, a reference ramp after deep.
	// Conversions stay refused while either count runs, trading a little latency for trusted results.
	// Light leaves the reference up, so only the short hold-off applies there.
	wire wake_event = powered_down & (nxt_pwr == ASC_ACTIVE);
	wire in_deep = (pwr_ff == ASC_DEEP);
	wire ref_ramping = (ref_cnt_ff > WAKE_W'(1));
	wire [CNT_W-1:0] nxt_wake_cnt = wake_event ? CNT_W'(LIGHT_WAKE_CYC) : dec_sat(wake_cnt_ff);
	wire [WAKE_W-1:0] ref_dec = ref_ramping ? (ref_cnt_ff - WAKE_W'(1)) : '0;
	wire [WAKE_W-1:0] nxt_ref_cnt = in_deep ? WAKE_W'(DEEP_WAKE_CYCLES) : ref_dec;
	wire nxt_ref_ok = ~in_deep & ~ref_ramping;

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wake_cnt_ff <= '0;
		end else begin
			wake_cnt_ff <= nxt_wake_cnt;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ref_cnt_ff <= '0;
		end else begin
			ref_cnt_ff <= nxt_ref_cnt;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ref_ok_ff <= 1'b1;
		end else begin
			ref_ok_ff <= nxt_ref_ok;
		end
	end

	// Conversion timer and early-clock detection.
	// The early window opens the clock after the take; a clock rise in the take cycle itself is not caught.
	// The conversion time is fixed; start edges inside it are dropped rather than queued.
	wire early_clock = busy_ff & sclk_rise & (early_cnt_ff != '0);
	wire nxt_busy = start_ok | (busy_ff & ~conversion_start_strobe_done);
	wire [CNT_W-1:0] nxt_conversion_start_strobe_cnt = start_ok ? CNT_W'(CONVERSION_START_STROBE_CYC_DEF) : dec_sat(conversion_start_strobe_cnt_ff);
	wire [CNT_W-1:0] nxt_early_cnt = start_ok ? CNT_W'(START_TO_CLOCK_CYC) : dec_sat(early_cnt_ff);
	wire nxt_early = ~start_ok & (early_ff | early_clock);

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			busy_ff <= 1'b0;
		end else begin
			busy_ff <= nxt_busy;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			conversion_start_strobe_cnt_ff <= '0;
		end else begin
			conversion_start_strobe_cnt_ff <= nxt_conversion_start_strobe_cnt;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			early_cnt_ff <= '0;
		end else begin
			early_cnt_ff <= nxt_early_cnt;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			early_ff <= 1'b0;
		end else begin
			early_ff <= nxt_early;
		end
	end

	// Serial word: flag first, then result most significant first, one bit per rising clock.
	// The last bit stands for a full clock like the others; the rise after it returns the line to zero.
	// A host that stops early leaves the rest of the word behind; the next take discards it.
	wire load_word = ~start_ok & conversion_start_strobe_done;
	wire shift_step = ~start_ok & ~conversion_start_strobe_done & shifting_ff & sclk_rise;
	wire word_out = (bit_cnt_ff > WORD_LAST);
	wire take_bit = shift_step & ~skip_ff & ~word_out;
	wire end_word = shift_step & ~skip_ff & word_out;
	wire [WORD_W-1:0] shifted = {shift_ff[WORD_W-2:0], 1'b0};
	wire [WORD_W-1:0] nxt_shift = load_word ? {ref_good, coded} : (take_bit ? shifted : shift_ff);
	wire [3:0] nxt_bit_cnt = load_word ? 4'h0 : (take_bit ? (bit_cnt_ff + 4'h1) : bit_cnt_ff);
	wire nxt_shifting = ~start_ok & (load_word | (shifting_ff & ~end_word));
	wire nxt_skip = load_word ? early_ff : (skip_ff & ~shift_step);
	wire nxt_sdata = take_bit ? shift_ff[WORD_W-1] : (o_sdata & ~end_word);

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			shift_ff <= '0;
		end else begin
			shift_ff <= nxt_shift;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			bit_cnt_ff <= 4'h0;
		end else begin
			bit_cnt_ff <= nxt_bit_cnt;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			shifting_ff <= 1'b0;
		end else begin
			shifting_ff <= nxt_shifting;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			skip_ff <= 1'b0;
		end else begin
			skip_ff <= nxt_skip;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_sdata <= 1'b0;
		end else begin
			o_sdata <= nxt_sdata;
		end
	end

	// Power and status outputs, all registered so the pins never glitch.
	// The enables follow the next state, so power drops in the same clock as the state changes.
	wire nxt_core_power_en = (nxt_pwr == ASC_ACTIVE);
	wire nxt_ref_power_en = (nxt_pwr != ASC_DEEP);

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_core_power_en <= 1'b1;
		end else begin
			o_core_power_en <= nxt_core_power_en;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_ref_power_en <= 1'b1;
		end else begin
			o_ref_power_en <= nxt_ref_power_en;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_reference_settled_flag <= 1'b1;
		end else begin
			o_reference_settled_flag <= ref_good;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_converting <= 1'b0;
		end else begin
			o_converting <= busy_ff;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_sample_req <= 1'b0;
		end else begin
			o_sample_req <= start_ok;
		end
	end
endmodule : asc_ctrl

// >>> tb/asc_ctrl_properties.sv
// Port checks for the converter control block.
`timescale 1ns/100ps
module asc_ctrl_properties #(
	parameter int DEEP_WAKE_CYCLES = asc_pkg::DEEP_WAKE_CYC
) (
	// Clock and reset.
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	// Watched ports.
	input wire logic i_sclk,
	input wire logic i_ref_low,
	input wire logic o_sdata,
	input wire logic o_core_power_en,
	input wire logic o_ref_power_en,
	input wire logic o_reference_settled_flag,
	input wire logic o_converting,
	input wire logic o_sample_req
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);
	// The converting flag follows the take pulse by one clock.
	a_conversion_start_strobe_run_length: assert property (o_sample_req |=> o_converting ##39 o_converting ##1 !o_converting)
		else $error("bad conversion length");
	a_light_core_off: assert property (!o_core_power_en |-> !o_converting) else $error("converting unpowered");
	a_deep_all_off: assert property (!o_ref_power_en |-> !o_core_power_en) else $error("core on in deep");
	// The window allows for the pin synchroniser but no change while the clock stays low.
	a_sdata_on_rise: assert property ($changed(o_sdata) |-> $past(i_sclk, 2) && !$past(i_sclk, 6))
		else $error("sdata moved without clock rise");
	a_deep_flag_low: assert property ($rose(o_ref_power_en) |=> !o_reference_settled_flag [*8])
		else $error("flag early after deep");
	a_ref_low_flag: assert property (i_ref_low [*3] |-> !o_reference_settled_flag) else $error("flag with low ref");
	a_deep_wake_ref: assert property ($rose(i_sclk) && !o_ref_power_en |-> ##[1:8] o_ref_power_en)
		else $error("no wake from deep");
	a_light_wake_time: assert property ($rose(i_sclk) && !o_core_power_en && o_ref_power_en |-> ##[1:12] o_core_power_en)
		else $error("slow light wake");
endmodule : asc_ctrl_properties

bind asc_ctrl asc_ctrl_properties #(.DEEP_WAKE_CYCLES(DEEP_WAKE_CYCLES)) u_props (.i_ref_clk(i_ref_clk),
	.i_rst_b(i_rst_b), .i_sclk(i_sclk), .i_ref_low(i_ref_low), .o_sdata(o_sdata), .o_core_power_en(o_core_power_en),
	.o_ref_power_en(o_ref_power_en), .o_reference_settled_flag(o_reference_settled_flag),
	.o_converting(o_converting), .o_sample_req(o_sample_req));

// >>> tb/asc_host.sv
// Host serial port model: clock, start strobe and word capture.
`timescale 1ns/100ps
module asc_host (
	// Clock and data in.
	input wire logic i_ref_clk,
	input wire logic i_sdata,
	// Pins to the device.
	output logic o_sclk,
	output logic o_strobe
);
	initial begin
		o_sclk = 1'b1;
		o_strobe = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge i_ref_clk);
		#5;
	endtask : wt
	// A short clock dip straight after the strobe lands inside the start-to-clock minimum.
	task automatic start(input logic fast);
		o_strobe = 1'b1;
		if (fast) begin
			wt(1);
			o_sclk = 1'b0;
			wt(1);
			o_sclk = 1'b1;
		end
		wt(2);
		o_strobe = 1'b0;
	endtask : start
	task automatic pulses(input int n);
		o_sclk = 1'b0;
		repeat (n) begin
			wt(2);
			o_strobe = 1'b1;
			wt(2);
			o_strobe = 1'b0;
		end
		wt(4);
	endtask : pulses
	task automatic wake();
		o_sclk = 1'b1;
	endtask : wake
	// Each bit is taken as the clock rises, so the first capture is stale and falls off the top.
	task automatic read(input int n, output logic [12:0] w);
		w = 13'h0000;
		repeat (n) begin
			o_sclk = 1'b0;
			wt(4);
			w = {w[11:0], i_sdata};
			o_sclk = 1'b1;
			wt(4);
		end
	endtask : read
endmodule : asc_host

// >>> tb/tb_adc_serial_conversion_start_strobe_power_control.sv
// Self-checking bench for the converter control block.
`timescale 1ns/100ps
module tb_adc_serial_conversion_start_strobe_power_control;
	import asc_pkg::*;
	localparam int DW = 50;
	logic i_ref_clk, i_rst_b, i_sclk, i_strobe, i_bipolar, i_ref_low;
	logic [RESULT_W-1:0] i_sar_code;
	logic o_sdata, o_core, o_ref, o_flag, o_conversion_start_strobe, o_req;
	int error_cnt = 0;
	int comparisons = 0;
	int cyc = 0;
	int reqs = 0;
	asc_ctrl #(.DEEP_WAKE_CYCLES(DW)) uut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_sclk(i_sclk),
		.i_conversion_start_strobe(i_strobe), .i_sar_code(i_sar_code), .i_bipolar(i_bipolar), .i_ref_low(i_ref_low),
		.o_sdata(o_sdata), .o_core_power_en(o_core), .o_ref_power_en(o_ref), .o_reference_settled_flag(o_flag),
		.o_converting(o_conversion_start_strobe), .o_sample_req(o_req));
	asc_host host (.i_ref_clk(i_ref_clk), .i_sdata(o_sdata), .o_sclk(i_sclk), .o_strobe(i_strobe));
	initial begin
		i_ref_clk = 1'b0;
		forever #25 i_ref_clk = ~i_ref_clk;
	end
	always @(posedge i_ref_clk) begin
		cyc <= cyc + 1;
		if (o_req === 1'b1) reqs <= reqs + 1;
		if (cyc == 5000) begin
			error_cnt++;
			end_sim();
		end
	end
	task automatic chk(input logic [12:0] got, input logic [12:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// The second strobe falls inside the running conversion and must not start another.
	task automatic t_conversion_start_strobe(input logic [11:0] code, input logic bip, input logic fast, input logic lowref);
		logic [12:0] w;
		int r;
		r = reqs;
		i_sar_code = code;
		i_bipolar = bip;
		host.start(fast);
		host.wt(10);
		i_ref_low = lowref;
		host.start(1'b0);
		host.wt(40);
		chk(13'(reqs - r), 13'h0001);
		host.read(14 + fast, w);
		chk(w, {~lowref, code ^ (bip ? BIPOLAR_FLIP : 12'h000)});
		i_ref_low = 1'b0;
	endtask : t_conversion_start_strobe
	task automatic t_power(input int n);
		host.pulses(n);
		chk(13'({o_core, o_ref}), 13'({n < 2, n < 4}));
		host.wake();
		host.wt(14);
		chk(13'(o_flag), 13'(n < 4));
		host.wt(DW);
		chk(13'({o_core, o_ref, o_flag}), 13'h0007);
	endtask : t_power
	task automatic end_sim();
		if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : end_sim
	initial begin
		i_rst_b = 1'b0;
		i_sar_code = 12'h000;
		i_bipolar = 1'b0;
		i_ref_low = 1'b0;
		repeat (4) @(posedge i_ref_clk);
		#5;
		i_rst_b = 1'b1;
		chk(13'({o_core, o_ref, o_flag, o_conversion_start_strobe}), 13'h000e);
		host.wt(2);
		t_conversion_start_strobe(12'h000, 1'b0, 1'b0, 1'b0);
		t_conversion_start_strobe(12'hfff, 1'b0, 1'b0, 1'b0);
		t_conversion_start_strobe(12'h7ff, 1'b1, 1'b0, 1'b0);
		t_conversion_start_strobe(12'h800, 1'b1, 1'b1, 1'b0);
		t_power(1);
		t_power(1);
		t_power(2);
		t_conversion_start_strobe(12'h3c1, 1'b0, 1'b0, 1'b0);
		t_power(4);
		t_conversion_start_strobe(12'ha5c, 1'b0, 1'b0, 1'b1);
		end_sim();
	end
endmodule : tb_adc_serial_conversion_start_strobe_power_control
